/* File: hw/panel_cfg_pkg.sv */
/*
  Package for the panel configuration and standby timer block: index values,
  field positions, reset values, mode encodings, timing constants and the
  struct that carries the decoded panel configuration.
  Assumes a single 25 MHz clock and the indexed I/O data port upstream.
*/
package panel_cfg_pkg;

  // ==========================================================================
  // register indices at the indexed data port
  localparam logic [7:0] IDX_PANEL_DISPLAY_CONTROL = 8'hDA;
  localparam logic [7:0] IDX_STANDBY_TIMER_CONTROL = 8'hDB;
  localparam logic [7:0] IDX_PANEL_COLOR_CONFIG = 8'hDC;

  // ==========================================================================
  // reset values
  localparam logic [7:0] RST_PANEL_DISPLAY_CONTROL = 8'h00;
  localparam logic [7:0] RST_STANDBY_TIMER_CONTROL = 8'h00;
  localparam logic [1:0] RST_PANEL_COLOR_CONFIG = 2'h0;

  // ==========================================================================
  // field positions
  localparam int WEIGHT_LSB = 5;
  localparam int SIZE_LSB = 3;
  localparam int ALIGN_LSB = 1;
  localparam int GRAY32_BIT = 0;
  localparam int TMODE_LSB = 6;
  localparam int TINTERVAL_LSB = 0;
  localparam int PIN_CTRL_BIT = 1;
  localparam int PIN_SEL9_BIT = 0;

  // ==========================================================================
  // weighting codes at and above this one are reserved
  localparam logic [2:0] WEIGHT_FIRST_RSVD = 3'h6;
  localparam logic [2:0] WEIGHT_DEFAULT = 3'h0;

  // ==========================================================================
  // timing: one minute of the 25 MHz clock
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned MINUTE_S = 60;
  localparam int unsigned MINUTE_CYCLES = CLK_HZ * MINUTE_S;
  localparam int PRESCALE_W = 31;

  // ==========================================================================
  // enumerations
  typedef enum logic [1:0] {
    TMR_OFF = 2'b00,
    TMR_SCREEN_SAVE_CLOCK_IN = 2'b01,
    TMR_VMEM = 2'b10,
    TMR_RSVD = 2'b11
  } timer_mode_t;

  typedef enum logic [1:0] {
    ALIGN_TOP = 2'b00,
    ALIGN_BOTTOM = 2'b01,
    ALIGN_CENTER = 2'b10
  } align_t;

  typedef enum logic [1:0] {
    SIZE_640X480 = 2'b00,
    SIZE_640X400 = 2'b01
  } panel_size_t;

  typedef enum logic [1:0] {
    PIN_AC_MODULATION = 2'b00,
    PIN_HORIZ_DISPLAY_ENABLE = 2'b01,
    PIN_COLOR9_PANEL = 2'b10
  } pin_func_t;

  // decoded panel configuration carried to the panel logic
  typedef struct packed {
    logic [2:0] weight;
    panel_size_t size;
    align_t align;
    logic gray32;
    pin_func_t pin_func;
  } panel_cfg_t;

endpackage

/* File: hw/standby_timer.sv */
/*
  Standby timer: a minute prescaler and a minute counter compared with the
  programmed interval; raises a level when the interval runs out.
  Assumes restart is a one-cycle pulse on the same clock as the timer.
*/
`timescale 1ns/1ps
module standby_timer #(
  parameter int unsigned MINUTE_CYCLES = panel_cfg_pkg::MINUTE_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_enable,
  input wire logic i_restart,
  input wire logic [5:0] i_interval,
  output logic o_expired
);

  typedef struct packed {
    logic [panel_cfg_pkg::PRESCALE_W-1:0] prescale;
    logic [5:0] minutes;
    logic expired;
  } timer_state_t;

  localparam logic [panel_cfg_pkg::PRESCALE_W-1:0] PRESCALE_LAST =
    panel_cfg_pkg::PRESCALE_W'(MINUTE_CYCLES - 1);

  timer_state_t s_reg;
  timer_state_t s_next;

  // ==========================================================================
  // counting
  // restart or disable clears; interval zero never expires
  always_comb begin
    s_next = s_reg;
    if (!i_enable || i_restart) begin
      s_next = '0;
    end else if (i_interval == 6'h00) begin
      s_next = '0;
    end else if (!s_reg.expired) begin
      if (s_reg.prescale == PRESCALE_LAST) begin
        s_next.prescale = '0;
        s_next.minutes = s_reg.minutes + 6'h01;
        if (s_reg.minutes + 6'h01 == i_interval) begin
          s_next.expired = 1'b1;
        end
      end else begin
        s_next.prescale = s_reg.prescale + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_expired = s_reg.expired;

  // ==========================================================================
  // checks
  property p_restart_clears;
    @(posedge i_clk) disable iff (i_rst)
    i_restart |=> !o_expired && s_reg.minutes == 6'h00;
  endproperty
  a_restart_clears: assert property (p_restart_clears) else $error("restart did not clear");

  property p_disabled_idle;
    @(posedge i_clk) disable iff (i_rst)
    !i_enable |=> !o_expired && s_reg.prescale == '0;
  endproperty
  a_disabled_idle: assert property (p_disabled_idle) else $error("disabled timer ran");

  property p_expiry_at_interval;
    @(posedge i_clk) disable iff (i_rst)
    $rose(o_expired) |-> s_reg.minutes == $past(i_interval) && $past(i_enable);
  endproperty
  a_expiry_at_interval: assert property (p_expiry_at_interval) else $error("early expiry");

  property p_zero_interval;
    @(posedge i_clk) disable iff (i_rst)
    i_interval == 6'h00 |=> !o_expired;
  endproperty
  a_zero_interval: assert property (p_zero_interval) else $error("zero interval expired");

endmodule

/* File: hw/panel_config_standby_timer.sv */
/*
  Panel configuration registers and standby timer control at the indexed
  I/O data port: panel display control, standby timer control and panel
  colour configuration, with their decoded outputs.
  Assumes the port index, data and read/write strobes arrive already decoded
  on i_clk; the screen save clock arrives from a pin and is synchronised here.
*/
`timescale 1ns/1ps
module panel_config_standby_timer #(
  parameter int unsigned MINUTE_CYCLES = panel_cfg_pkg::MINUTE_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_index,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [7:0] i_wdata,
  input wire logic i_screen_save_clock_in,
  input wire logic i_vmem_access,
  output logic [7:0] o_rdata,
  output logic o_rdata_valid,
  output panel_cfg_pkg::panel_cfg_t o_panel_cfg,
  output logic o_standby_req
);

  typedef struct packed {
    logic ssc_meta;
    logic ssc_sync;
    logic ssc_prev;
    logic [7:0] panel_display_control;
    logic [7:0] standby_timer_control;
    logic [1:0] panel_color_config;
    logic [7:0] rdata;
    logic rdata_valid;
    panel_cfg_pkg::panel_cfg_t cfg;
    logic standby;
  } top_state_t;

  top_state_t s_reg;
  top_state_t s_next;
  logic timer_expired;
  logic timer_enable;
  logic timer_restart;
  panel_cfg_pkg::timer_mode_t tmode;
  logic hit_da;
  logic hit_db;
  logic hit_dc;

  // ==========================================================================
  // index decode and timer control
  assign hit_da = i_index == panel_cfg_pkg::IDX_PANEL_DISPLAY_CONTROL;
  assign hit_db = i_index == panel_cfg_pkg::IDX_STANDBY_TIMER_CONTROL;
  assign hit_dc = i_index == panel_cfg_pkg::IDX_PANEL_COLOR_CONFIG;
  assign tmode = panel_cfg_pkg::timer_mode_t'(
    s_reg.standby_timer_control[panel_cfg_pkg::TMODE_LSB +: 2]);

  // restart sources per mode; a write to the timer register also restarts
  always_comb begin
    timer_enable = (tmode == panel_cfg_pkg::TMR_SCREEN_SAVE_CLOCK_IN) ||
      (tmode == panel_cfg_pkg::TMR_VMEM);
    timer_restart = (i_io_wr && hit_db) ||
      ((tmode == panel_cfg_pkg::TMR_SCREEN_SAVE_CLOCK_IN) && (s_reg.ssc_sync ^ s_reg.ssc_prev)) ||
      ((tmode == panel_cfg_pkg::TMR_VMEM) && i_vmem_access);
  end

  standby_timer #(
    .MINUTE_CYCLES(MINUTE_CYCLES)
  ) u_timer (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_enable(timer_enable),
    .i_restart(timer_restart),
    .i_interval(s_reg.standby_timer_control[panel_cfg_pkg::TINTERVAL_LSB +: 6]),
    .o_expired(timer_expired)
  );

  // ==========================================================================
  // register writes, reads and field decode
  always_comb begin
    s_next = s_reg;
    // pin synchroniser: meta is read only by sync
    s_next.ssc_meta = i_screen_save_clock_in;
    s_next.ssc_sync = s_reg.ssc_meta;
    s_next.ssc_prev = s_reg.ssc_sync;
    if (i_io_wr) begin
      if (hit_da) begin
        s_next.panel_display_control = i_wdata;
      end
      if (hit_db) begin
        s_next.standby_timer_control = i_wdata;
      end
      if (hit_dc) begin
        s_next.panel_color_config = i_wdata[1:0];
      end
    end
    // read returns the value held before any same-cycle write
    s_next.rdata = 8'h00;
    s_next.rdata_valid = i_io_rd && (hit_da || hit_db || hit_dc);
    if (i_io_rd) begin
      if (hit_da) begin
        s_next.rdata = s_reg.panel_display_control;
      end else if (hit_db) begin
        s_next.rdata = s_reg.standby_timer_control;
      end else if (hit_dc) begin
        s_next.rdata = {6'h00, s_reg.panel_color_config};
      end
    end
    // weighting: reserved codes fall back to the default
    s_next.cfg.weight = s_next.panel_display_control[panel_cfg_pkg::WEIGHT_LSB +: 3];
    if (s_next.cfg.weight >= panel_cfg_pkg::WEIGHT_FIRST_RSVD) begin
      s_next.cfg.weight = panel_cfg_pkg::WEIGHT_DEFAULT;
    end
    // panel size: reserved codes fall back to 640x480
    if (s_next.panel_display_control[panel_cfg_pkg::SIZE_LSB +: 2] == 2'b01) begin
      s_next.cfg.size = panel_cfg_pkg::SIZE_640X400;
    end else begin
      s_next.cfg.size = panel_cfg_pkg::SIZE_640X480;
    end
    // vertical alignment: upper bit set means centre
    if (s_next.panel_display_control[panel_cfg_pkg::ALIGN_LSB + 1]) begin
      s_next.cfg.align = panel_cfg_pkg::ALIGN_CENTER;
    end else if (s_next.panel_display_control[panel_cfg_pkg::ALIGN_LSB]) begin
      s_next.cfg.align = panel_cfg_pkg::ALIGN_BOTTOM;
    end else begin
      s_next.cfg.align = panel_cfg_pkg::ALIGN_TOP;
    end
    s_next.cfg.gray32 = s_next.panel_display_control[panel_cfg_pkg::GRAY32_BIT];
    // shared panel pin: the 9-bit selection wins over the other bit
    if (s_next.panel_color_config[panel_cfg_pkg::PIN_CTRL_BIT]) begin
      s_next.cfg.pin_func = panel_cfg_pkg::PIN_COLOR9_PANEL;
    end else if (s_next.panel_color_config[panel_cfg_pkg::PIN_SEL9_BIT]) begin
      s_next.cfg.pin_func = panel_cfg_pkg::PIN_HORIZ_DISPLAY_ENABLE;
    end else begin
      s_next.cfg.pin_func = panel_cfg_pkg::PIN_AC_MODULATION;
    end
    s_next.standby = timer_expired;
  end

  // state register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s_reg <= '0;
      s_reg.panel_display_control <= panel_cfg_pkg::RST_PANEL_DISPLAY_CONTROL;
      s_reg.standby_timer_control <= panel_cfg_pkg::RST_STANDBY_TIMER_CONTROL;
      s_reg.panel_color_config <= panel_cfg_pkg::RST_PANEL_COLOR_CONFIG;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_rdata = s_reg.rdata;
  assign o_rdata_valid = s_reg.rdata_valid;
  assign o_panel_cfg = s_reg.cfg;
  assign o_standby_req = s_reg.standby;

  // ==========================================================================
  // checks
  sequence s_wr_da;
    i_io_wr && hit_da;
  endsequence

  sequence s_wr_dc;
    i_io_wr && hit_dc;
  endsequence

  property p_weight;
    @(posedge i_clk) disable iff (i_rst)
    s_wr_da |=> o_panel_cfg.weight == (($past(i_wdata[7:5]) >= 3'h6) ? 3'h0 : $past(i_wdata[7:5]));
  endproperty
  a_weight: assert property (p_weight) else $error("weighting decode wrong");

  property p_size;
    @(posedge i_clk) disable iff (i_rst)
    s_wr_da |=> (o_panel_cfg.size == panel_cfg_pkg::SIZE_640X400) == ($past(i_wdata[4:3]) == 2'b01);
  endproperty
  a_size: assert property (p_size) else $error("panel size decode wrong");

  property p_align_center;
    @(posedge i_clk) disable iff (i_rst)
    s_wr_da ##0 i_wdata[2] |=> o_panel_cfg.align == panel_cfg_pkg::ALIGN_CENTER;
  endproperty
  a_align_center: assert property (p_align_center) else $error("centre alignment missed");

  property p_gray32;
    @(posedge i_clk) disable iff (i_rst)
    s_wr_da |=> o_panel_cfg.gray32 == $past(i_wdata[0]);
  endproperty
  a_gray32: assert property (p_gray32) else $error("gray limit not applied");

  property p_pin_override;
    @(posedge i_clk) disable iff (i_rst)
    s_wr_dc ##0 i_wdata[1] |=> o_panel_cfg.pin_func == panel_cfg_pkg::PIN_COLOR9_PANEL;
  endproperty
  a_pin_override: assert property (p_pin_override) else $error("9-bit select not dominant");

  property p_readback;
    @(posedge i_clk) disable iff (i_rst)
    (i_io_wr && hit_db && !i_io_rd) ##1 (i_io_rd && hit_db && !i_io_wr)
      |=> o_rdata_valid && o_rdata == $past(i_wdata, 2);
  endproperty
  a_readback: assert property (p_readback) else $error("timer register readback wrong");

  property p_reserved_zero;
    @(posedge i_clk) disable iff (i_rst)
    i_io_rd && hit_dc |=> o_rdata[7:2] == 6'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

  property p_vmem_restart;
    @(posedge i_clk) disable iff (i_rst)
    (tmode == panel_cfg_pkg::TMR_VMEM) && i_vmem_access |-> ##2 !o_standby_req;
  endproperty
  a_vmem_restart: assert property (p_vmem_restart) else $error("vmem access did not restart");

endmodule

/* File: testbench/host_model.sv */
/*
  Host processor model: drives the indexed data port strobes, video memory
  access pulses and the screen save pin.
  Assumes a 25 MHz clock; every input changes at the falling edge.
*/
`timescale 1ns/1ps
module host_model (
  input wire logic i_clk,
  output logic [7:0] o_index,
  output logic o_io_wr,
  output logic o_io_rd,
  output logic [7:0] o_wdata,
  output logic o_vmem_access,
  output logic o_screen_save_clock_in
);
  // ==========================================================================
  // idle levels at time zero
  initial begin
    o_index = 8'h00;
    o_io_wr = 1'b0;
    o_io_rd = 1'b0;
    o_wdata = 8'h00;
    o_vmem_access = 1'b0;
    o_screen_save_clock_in = 1'b0;
  end

  // one strobe for one edge; released lines are scrambled, not held
  task automatic access(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    @(negedge i_clk);
    o_index = idx;
    o_wdata = d;
    o_io_wr = wr;
    o_io_rd = !wr;
    @(negedge i_clk);
    o_io_wr = 1'b0;
    o_io_rd = 1'b0;
    o_index = ~idx;
    o_wdata = ~d;
  endtask

  // write one index, then read it back on the very next edge
  task automatic write_read(input logic [7:0] idx, input logic [7:0] d);
    @(negedge i_clk);
    o_index = idx;
    o_wdata = d;
    o_io_wr = 1'b1;
    o_io_rd = 1'b0;
    @(negedge i_clk);
    o_io_wr = 1'b0;
    o_io_rd = 1'b1;
    o_wdata = ~d;
    @(negedge i_clk);
    o_io_rd = 1'b0;
    o_index = ~idx;
  endtask

  // one video memory access, one cycle wide
  task automatic vmem_pulse;
    @(negedge i_clk);
    o_vmem_access = 1'b1;
    @(negedge i_clk);
    o_vmem_access = 1'b0;
  endtask

  // one edge of activity on the screen save pin
  task automatic pin_toggle;
    @(negedge i_clk);
    o_screen_save_clock_in = ~o_screen_save_clock_in;
    @(negedge i_clk);
  endtask
endmodule

/* File: testbench/panel_config_standby_timer_tb_top.sv */
/*
  Self-checking bench for the panel configuration and standby timer block.
  Assumes the host model drives the port; the minute is shortened to 4 cycles.
*/
`timescale 1ns/1ps
module panel_config_standby_timer_tb_top;
  localparam int unsigned MC = 4;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] i_index, i_wdata, o_rdata, a, c, d;
  logic i_io_wr, i_io_rd, i_screen_save_clock_in, i_vmem_access;
  logic o_rdata_valid, o_standby_req;
  panel_cfg_pkg::panel_cfg_t o_panel_cfg;
  logic [7:0] exp_q[$];
  int failures = 0;
  int samples_checked = 0;
  int seed = 32'hf8c1846c;
  // timer settings that must never raise standby: reserved mode, zero interval, off
  logic [7:0] dis_vals [3] = '{8'hC1, 8'h80, 8'h01};

  // ==========================================================================
  // clock, partner and design
  always #20 i_clk = ~i_clk;

  host_model host_u (.i_clk(i_clk), .o_index(i_index), .o_io_wr(i_io_wr),
    .o_io_rd(i_io_rd), .o_wdata(i_wdata), .o_vmem_access(i_vmem_access),
    .o_screen_save_clock_in(i_screen_save_clock_in));

  panel_config_standby_timer #(.MINUTE_CYCLES(MC)) dut_u (.i_clk(i_clk), .i_rst(i_rst),
    .i_index(i_index), .i_io_wr(i_io_wr), .i_io_rd(i_io_rd), .i_wdata(i_wdata),
    .i_screen_save_clock_in(i_screen_save_clock_in), .i_vmem_access(i_vmem_access),
    .o_rdata(o_rdata), .o_rdata_valid(o_rdata_valid), .o_panel_cfg(o_panel_cfg),
    .o_standby_req(o_standby_req));

  // ==========================================================================
  // shared tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR time %0t seen 0x%0h expected 0x%0h", $time, seen, exp);
    end
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    exp_q.push_back(exp);
    host_u.access(1'b0, idx, 8'h00);
  endtask

  // low through lo cycles after a restart, high by hi cycles
  task automatic expect_expiry(input int lo, input int hi);
    repeat (lo) @(negedge i_clk);
    check(o_standby_req, 1'b0);
    repeat (hi - lo) @(negedge i_clk);
    check(o_standby_req, 1'b1);
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // expected decode of the two panel registers
  function automatic panel_cfg_pkg::panel_cfg_t cfg_of(input logic [7:0] x, input logic [7:0] y);
    panel_cfg_pkg::panel_cfg_t r;
    r.weight = (x[7:5] >= 3'h6) ? 3'h0 : x[7:5];
    r.size = panel_cfg_pkg::panel_size_t'(x[4] ? 2'h0 : x[4:3]);
    r.align = panel_cfg_pkg::align_t'(x[2] ? 2'h2 : x[2:1]);
    r.gray32 = x[0];
    r.pin_func = panel_cfg_pkg::pin_func_t'(y[1] ? 2'h2 : {1'b0, y[0]});
    return r;
  endfunction

  // ==========================================================================
  // read answer monitor: oldest note against each answer
  always @(negedge i_clk) begin
    if (!i_rst) begin
      if (o_rdata_valid !== 1'b0) begin
        if (exp_q.size() > 0) check(o_rdata, exp_q.pop_front());
        else check(o_rdata_valid, 1'b0);
      end else check(o_rdata, 8'h00);
    end
  end

  // watchdog
  initial begin
    #(40 * 20000);
    failures++;
    report_and_stop();
  end

  // ==========================================================================
  // main sequence
  initial begin
    repeat (10) @(negedge i_clk);
    i_rst = 1'b0;
    rd(8'hDA, 8'h00);
    rd(8'hDB, 8'h00);
    rd(8'hDC, 8'h00);
    check(o_panel_cfg, 11'h000);
    check(o_standby_req, 1'b0);
    $display("test reset values done");
    c = 8'h00;
    for (int i = 0; i < 16; i++) begin
      a = (i < 8) ? {i[2:0], i[1:0], i[2:1], i[0]} : 8'($random(seed));
      host_u.access(1'b1, 8'hDA, a);
      check(o_panel_cfg, cfg_of(a, c));
      rd(8'hDA, a);
    end
    $display("test display control done");
    for (int i = 0; i < 8; i++) begin
      c = {8'($random(seed)) & 8'hFC} | {6'h00, i[1:0]};
      host_u.access(1'b1, 8'hDC, c);
      check(o_panel_cfg, cfg_of(a, c));
      rd(8'hDC, {6'h00, c[1:0]});
    end
    $display("test colour config done");
    host_u.access(1'b1, 8'hDD, 8'hFF);
    host_u.access(1'b1, 8'hD9, 8'hFF);
    host_u.access(1'b0, 8'hD9, 8'h00);
    check(o_panel_cfg, cfg_of(a, c));
    rd(8'hDA, a);
    for (int i = 0; i < 4; i++) begin
      d = {i[1:0], 6'($random(seed))};
      exp_q.push_back(d);
      host_u.write_read(8'hDB, d);
    end
    $display("test index decode done");
    host_u.access(1'b1, 8'hDB, 8'h81);
    expect_expiry(MC, MC + 3);
    host_u.access(1'b1, 8'hDB, 8'h01);
    repeat (3) @(negedge i_clk);
    check(o_standby_req, 1'b0);
    host_u.access(1'b1, 8'hDB, 8'h82);
    repeat (20) host_u.vmem_pulse();
    check(o_standby_req, 1'b0);
    expect_expiry(2 * MC, 2 * MC + 3);
    host_u.access(1'b1, 8'hDB, 8'h41);
    repeat (4) host_u.vmem_pulse();
    check(o_standby_req, 1'b1);
    repeat (20) host_u.pin_toggle();
    check(o_standby_req, 1'b0);
    expect_expiry(MC, MC + 8);
    host_u.access(1'b1, 8'hDB, 8'h81);
    repeat (4) host_u.pin_toggle();
    check(o_standby_req, 1'b1);
    $display("test restart sources done");
    foreach (dis_vals[k]) begin
      host_u.access(1'b1, 8'hDB, dis_vals[k]);
      repeat (12) @(negedge i_clk);
      check(o_standby_req, 1'b0);
    end
    $display("test disabled timer done");
    check(exp_q.size(), 16'h0000);
    report_and_stop();
  end
endmodule
